// ==== core/frame_pulse_generator.sv ====
/*
 * Frame pulse source of the deserializer hub: register set, pin relay, tick
 * source choice and back-channel slot routing around the waveform engine.
 * Assumes the register port is driven by the control-bus slave on CORE_CLK,
 * and pins arrive asynchronously.
 */
// Contract
// - codes 8..F relay pin (code minus 8)
// - slot carries pulse only when routed there
// - all four back channels switch together
// - fast rate tick is 600 ns
// - slow rate tick is 12 us
// - rate code 110b selects fast rate
// - enable bit starts internal generation
// - generation repeats without software help
// - code 0 ticks from port 0 frame
// - shape bit picks separate or even halves
// - init bit sets starting level
// - high count bytes at 0x19 and 0x1A
// - low count bytes at 0x1B and 0x1C
`timescale 1ns/1ps
`include "fpg_defines.svh"
module frame_pulse_generator #(
  parameter int NUM_PORTS = 4,
  parameter int NUM_SLOTS = 4,
  parameter int NUM_PINS = 8,
  parameter int FAST_CYCLES = `FPG_TICK_FAST_CYCLES,
  parameter int SLOW_CYCLES = `FPG_TICK_SLOW_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WRITE,
  input wire logic REG_READ,
  output logic [7:0] REG_RDATA,
  // general-purpose pins
  input wire logic [NUM_PINS-1:0] GPIO_IN,
  // back-channel slots and pulse
  output logic [NUM_PORTS*NUM_SLOTS-1:0] BC_SLOT_OUT,
  output logic FRAME_PULSE_OUT
);
  logic [7:0] ctrl_reg;
  logic [15:0] high_count_reg;
  logic [15:0] low_count_reg;
  logic [7:0] page_reg;
  logic [2:0] rate_reg [NUM_PORTS];
  logic [15:0] route_reg [NUM_PORTS];
  logic [NUM_PINS-1:0] pin_s1_reg;
  logic [NUM_PINS-1:0] pin_s2_reg;
  logic [NUM_PINS-1:0] pin_s3_reg;
  logic [NUM_PINS-1:0] pin_filt_reg;
  logic frame_pulse_reg;
  logic frame_pulse_next;
  logic [NUM_PORTS*NUM_SLOTS-1:0] slot_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] source_sel;
  logic ext_mode;
  logic [1:0] tick_port;
  logic [1:0] read_port;

  pulse_ctrl_if gen_ctl ();

  assign source_sel = ctrl_reg[`FPG_CTL_MODE_MSB:`FPG_CTL_MODE_LSB];
  assign ext_mode = source_sel[`FPG_MODE_EXT];
  assign tick_port = source_sel[1:0];
  assign read_port = page_reg[`FPG_PAGE_RD_MSB:`FPG_PAGE_RD_LSB];

  // relay mode keeps the engine parked even if software leaves enable set
  assign gen_ctl.enable = ctrl_reg[`FPG_CTL_EN] && !ext_mode;
  assign gen_ctl.shape_equal = ctrl_reg[`FPG_CTL_SHAPE];
  assign gen_ctl.init_level = ctrl_reg[`FPG_CTL_INIT];
  assign gen_ctl.fast_rate = (rate_reg[tick_port] == `FPG_RATE_FAST);
  assign gen_ctl.high_count = high_count_reg;
  assign gen_ctl.low_count = low_count_reg;

  pulse_waveform #(
    .FAST_CYCLES(FAST_CYCLES),
    .SLOW_CYCLES(SLOW_CYCLES)
  ) u_wave (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .ctl(gen_ctl)
  );

  // shared registers
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= `FPG_CTRL_RST;
      page_reg <= `FPG_PAGE_RST;
    end else if (REG_WRITE) begin
      if (REG_ADDR == `FPG_OFF_CTRL) begin
        ctrl_reg <= REG_WDATA;
      end
      if (REG_ADDR == `FPG_OFF_PAGE) begin
        page_reg <= REG_WDATA;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      high_count_reg <= `FPG_COUNT_RST;
    end else if (REG_WRITE && REG_ADDR == `FPG_OFF_HIGH_UP) begin
      high_count_reg[15:8] <= REG_WDATA;
    end else if (REG_WRITE && REG_ADDR == `FPG_OFF_HIGH_LO) begin
      high_count_reg[7:0] <= REG_WDATA;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_count_reg <= `FPG_COUNT_RST;
    end else if (REG_WRITE && REG_ADDR == `FPG_OFF_LOW_UP) begin
      low_count_reg[15:8] <= REG_WDATA;
    end else if (REG_WRITE && REG_ADDR == `FPG_OFF_LOW_LO) begin
      low_count_reg[7:0] <= REG_WDATA;
    end
  end

  // per-port registers, written to every port whose page bit is set
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        rate_reg[p] <= `FPG_RATE_RST;
        route_reg[p] <= `FPG_ROUTE_RST;
      end else if (REG_WRITE && page_reg[p]) begin
        if (REG_ADDR == `FPG_OFF_RATE) begin
          rate_reg[p] <= REG_WDATA[2:0];
        end
        if (REG_ADDR == `FPG_OFF_ROUTE_LO) begin
          route_reg[p][7:0] <= REG_WDATA;
        end
        if (REG_ADDR == `FPG_OFF_ROUTE_HI) begin
          route_reg[p][15:8] <= REG_WDATA;
        end
      end
    end
    for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
      // one shared pulse flop feeds every slot, so ports stay in step
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          slot_reg[p*NUM_SLOTS+s] <= 1'b0;
        end else begin
          slot_reg[p*NUM_SLOTS+s] <= frame_pulse_reg &&
            (route_reg[p][s*4+:4] == `FPG_ROUTE_PULSE);
        end
      end
    end
  end

  // pin synchronisers; only the filtered level is ever used
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        pin_s1_reg[g] <= 1'b0;
        pin_s2_reg[g] <= 1'b0;
        pin_s3_reg[g] <= 1'b0;
        pin_filt_reg[g] <= 1'b0;
      end else begin
        pin_s1_reg[g] <= GPIO_IN[g];
        pin_s2_reg[g] <= pin_s1_reg[g];
        pin_s3_reg[g] <= pin_s2_reg[g];
        if (pin_s2_reg[g] == pin_s3_reg[g]) begin
          pin_filt_reg[g] <= pin_s3_reg[g];
        end
      end
    end
  end

  always_comb begin
    if (ext_mode) begin
      frame_pulse_next = pin_filt_reg[source_sel[2:0]];
    end else begin
      frame_pulse_next = gen_ctl.pulse;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      frame_pulse_reg <= 1'b0;
    end else begin
      frame_pulse_reg <= frame_pulse_next;
    end
  end

  // read side; bit 3 of the control register shows the live pulse
  always_comb begin
    case (REG_ADDR)
      `FPG_OFF_CTRL: rdata_next = {ctrl_reg[7:4], frame_pulse_reg, ctrl_reg[2:0]};
      `FPG_OFF_HIGH_UP: rdata_next = high_count_reg[15:8];
      `FPG_OFF_HIGH_LO: rdata_next = high_count_reg[7:0];
      `FPG_OFF_LOW_UP: rdata_next = low_count_reg[15:8];
      `FPG_OFF_LOW_LO: rdata_next = low_count_reg[7:0];
      `FPG_OFF_PAGE: rdata_next = page_reg;
      `FPG_OFF_RATE: rdata_next = {5'h00, rate_reg[read_port]};
      `FPG_OFF_ROUTE_LO: rdata_next = route_reg[read_port][7:0];
      `FPG_OFF_ROUTE_HI: rdata_next = route_reg[read_port][15:8];
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_reg <= 8'h00;
    end else if (REG_READ) begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;
  assign BC_SLOT_OUT = slot_reg;
  assign FRAME_PULSE_OUT = frame_pulse_reg;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_rate_fast_write;
    REG_WRITE && REG_ADDR == `FPG_OFF_RATE && page_reg[0] &&
      REG_WDATA[2:0] == `FPG_RATE_FAST && source_sel == 4'h0;
  endsequence

  property p_ext_select;
    ext_mode |=> frame_pulse_reg == $past(pin_filt_reg[source_sel[2:0]]);
  endproperty
  a_ext_select: assert property (p_ext_select) else $error("pin relay wrong");
  property p_slot_route;
    1'b1 |=> slot_reg[0] ==
      ($past(frame_pulse_reg) && $past(route_reg[0][3:0]) == `FPG_ROUTE_PULSE);
  endproperty
  a_slot_route: assert property (p_slot_route) else $error("slot routing wrong");
  property p_ports_aligned;
    route_reg[0][3:0] == `FPG_ROUTE_PULSE && route_reg[1][3:0] == `FPG_ROUTE_PULSE &&
      route_reg[2][3:0] == `FPG_ROUTE_PULSE && route_reg[3][3:0] == `FPG_ROUTE_PULSE
      |=> slot_reg[0] == slot_reg[4] && slot_reg[4] == slot_reg[8] &&
      slot_reg[8] == slot_reg[12];
  endproperty
  a_ports_aligned: assert property (p_ports_aligned) else $error("ports skewed");
  property p_rate_fast;
    s_rate_fast_write |=> gen_ctl.fast_rate;
  endproperty
  a_rate_fast: assert property (p_rate_fast) else $error("fast rate not taken");
  property p_tick_port0;
    source_sel == 4'h0 && $stable(rate_reg[0]) |-> ##1 ($past(source_sel) == 4'h0 &&
      $past(rate_reg[0]) != `FPG_RATE_FAST) |-> !$past(gen_ctl.fast_rate);
  endproperty
  a_tick_port0: assert property (p_tick_port0) else $error("tick port wrong");
  property p_high_bytes;
    REG_WRITE && REG_ADDR == `FPG_OFF_HIGH_UP |=>
      high_count_reg[15:8] == $past(REG_WDATA) && $stable(high_count_reg[7:0]);
  endproperty
  a_high_bytes: assert property (p_high_bytes) else $error("high count write");
  property p_low_bytes;
    REG_WRITE && REG_ADDR == `FPG_OFF_LOW_LO |=>
      low_count_reg[7:0] == $past(REG_WDATA) && $stable(low_count_reg[15:8]);
  endproperty
  a_low_bytes: assert property (p_low_bytes) else $error("low count write");

  // register, pin and path checks; pin checks watch bit 0 only to keep them cheap
  property p_ctrl_write;
    REG_WRITE && REG_ADDR == `FPG_OFF_CTRL |=> ctrl_reg == $past(REG_WDATA);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");
  property p_internal_out;
    !ext_mode |=> frame_pulse_reg == $past(gen_ctl.pulse);
  endproperty
  a_internal_out: assert property (p_internal_out) else $error("pulse not passed");
  property p_pin_agree;
    pin_s2_reg[0] == pin_s3_reg[0] |=> pin_filt_reg[0] == $past(pin_s3_reg[0]);
  endproperty
  a_pin_agree: assert property (p_pin_agree) else $error("pin level not taken");
  property p_pin_hold;
    pin_s2_reg[0] != pin_s3_reg[0] |=> $stable(pin_filt_reg[0]);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin glitch passed");
  property p_route_write;
    REG_WRITE && REG_ADDR == `FPG_OFF_ROUTE_HI && page_reg[2] |=>
      route_reg[2][15:8] == $past(REG_WDATA);
  endproperty
  a_route_write: assert property (p_route_write) else $error("route write lost");
  property p_page_mask;
    REG_WRITE && REG_ADDR == `FPG_OFF_RATE && !page_reg[2] |=> $stable(rate_reg[2]);
  endproperty
  a_page_mask: assert property (p_page_mask) else $error("masked port written");
  property p_slot_unrouted;
    route_reg[2][15:12] != `FPG_ROUTE_PULSE |=> !slot_reg[11];
  endproperty
  a_slot_unrouted: assert property (p_slot_unrouted) else $error("stray slot");
  property p_read_high;
    REG_READ && REG_ADDR == `FPG_OFF_HIGH_UP |=> REG_RDATA == $past(high_count_reg[15:8]);
  endproperty
  a_read_high: assert property (p_read_high) else $error("high count read");
  property p_low_upper;
    REG_WRITE && REG_ADDR == `FPG_OFF_LOW_UP |=>
      low_count_reg[15:8] == $past(REG_WDATA) && $stable(low_count_reg[7:0]);
  endproperty
  a_low_upper: assert property (p_low_upper) else $error("low count upper write");
  property p_pulse_status;
    REG_READ && REG_ADDR == `FPG_OFF_CTRL |=> REG_RDATA[3] == $past(frame_pulse_reg);
  endproperty
  a_pulse_status: assert property (p_pulse_status) else $error("status bit wrong");
endmodule

// ==== core/fpg_defines.svh ====
/*
 * Register offsets, field positions, reset values and timing counts of the
 * frame pulse generator. Assumes an 8-bit register port and a 100 MHz core clock.
 */
`ifndef FPG_DEFINES_SVH
`define FPG_DEFINES_SVH

`define FPG_OFF_CTRL 8'h18
`define FPG_OFF_HIGH_UP 8'h19
`define FPG_OFF_HIGH_LO 8'h1A
`define FPG_OFF_LOW_UP 8'h1B
`define FPG_OFF_LOW_LO 8'h1C
`define FPG_OFF_PAGE 8'h4C
`define FPG_OFF_RATE 8'h58
`define FPG_OFF_ROUTE_LO 8'h6E
`define FPG_OFF_ROUTE_HI 8'h6F

`define FPG_CTL_EN 0
`define FPG_CTL_SHAPE 1
`define FPG_CTL_INIT 2
`define FPG_CTL_STAT 3
`define FPG_CTL_MODE_MSB 7
`define FPG_CTL_MODE_LSB 4
`define FPG_MODE_EXT 3
`define FPG_PAGE_RD_MSB 5
`define FPG_PAGE_RD_LSB 4

`define FPG_RATE_FAST 3'h6
`define FPG_ROUTE_PULSE 4'hA

`define FPG_CTRL_RST 8'h00
`define FPG_COUNT_RST 16'h0000
`define FPG_PAGE_RST 8'h00
`define FPG_RATE_RST 3'h0
`define FPG_ROUTE_RST 16'h0000

`define FPG_CLK_PERIOD_NS 10
`define FPG_BC_FRAME_BITS 30
`define FPG_BIT_FAST_NS 20
`define FPG_BIT_SLOW_NS 400
`define FPG_TICK_FAST_CYCLES (`FPG_BC_FRAME_BITS * `FPG_BIT_FAST_NS / `FPG_CLK_PERIOD_NS)
`define FPG_TICK_SLOW_CYCLES (`FPG_BC_FRAME_BITS * `FPG_BIT_SLOW_NS / `FPG_CLK_PERIOD_NS)

`endif

// ==== core/fpg_pkg.sv ====
/*
 * Types shared by the frame pulse generator modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package fpg_pkg;
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_HIGH = 2'b01,
    GEN_LOW = 2'b10
  } gen_state_t;
  typedef logic [15:0] tick_count_t;
endpackage

// ==== core/pulse_ctrl_if.sv ====
/*
 * Settings and result between the register block and the waveform engine.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface pulse_ctrl_if;
  logic enable;
  logic shape_equal;
  logic init_level;
  logic fast_rate;
  fpg_pkg::tick_count_t high_count;
  fpg_pkg::tick_count_t low_count;
  logic pulse;
  modport ctrl (output enable, shape_equal, init_level, fast_rate, high_count, low_count,
    input pulse);
  modport gen (input enable, shape_equal, init_level, fast_rate, high_count, low_count,
    output pulse);
endinterface

// ==== core/pulse_waveform.sv ====
/*
 * Tick divider and high/low waveform engine of the internal frame pulse.
 * Assumes settings arrive already registered on the same core clock.
 */
`timescale 1ns/1ps
`include "fpg_defines.svh"
module pulse_waveform #(
  parameter int FAST_CYCLES = `FPG_TICK_FAST_CYCLES,
  parameter int SLOW_CYCLES = `FPG_TICK_SLOW_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  pulse_ctrl_if.gen ctl
);
  localparam int CW = $clog2(SLOW_CYCLES + 1);
  localparam logic [CW-1:0] FAST_LAST = CW'(FAST_CYCLES - 1);
  localparam logic [CW-1:0] SLOW_LAST = CW'(SLOW_CYCLES - 1);

  logic [CW-1:0] div_reg;
  logic tick_reg;
  logic rate_last_reg;
  fpg_pkg::gen_state_t state_reg;
  fpg_pkg::tick_count_t cnt_reg;
  logic out_reg;
  logic [CW-1:0] div_last;
  fpg_pkg::tick_count_t high_len;
  fpg_pkg::tick_count_t low_len;

  assign div_last = ctl.fast_rate ? FAST_LAST : SLOW_LAST;
  // zero counts would stall the wave, so they act as one tick
  assign high_len = (ctl.high_count == 16'h0000) ? 16'h0001 : ctl.high_count;
  assign low_len = ctl.shape_equal ? high_len :
    ((ctl.low_count == 16'h0000) ? 16'h0001 : ctl.low_count);
  assign ctl.pulse = out_reg;

  // one tick per back-channel frame; a rate change restarts the frame
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
      rate_last_reg <= 1'b0;
    end else if (!ctl.enable || ctl.fast_rate != rate_last_reg) begin
      div_reg <= '0;
      tick_reg <= 1'b0;
      rate_last_reg <= ctl.fast_rate;
    end else if (div_reg == div_last) begin
      div_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fpg_pkg::GEN_IDLE;
      cnt_reg <= '0;
      out_reg <= 1'b0;
    end else if (!ctl.enable) begin
      state_reg <= fpg_pkg::GEN_IDLE;
      cnt_reg <= '0;
      out_reg <= ctl.init_level;
    end else begin
      case (state_reg)
        fpg_pkg::GEN_IDLE: begin
          state_reg <= ctl.init_level ? fpg_pkg::GEN_HIGH : fpg_pkg::GEN_LOW;
          cnt_reg <= '0;
          out_reg <= ctl.init_level;
        end
        fpg_pkg::GEN_HIGH: begin
          if (tick_reg && cnt_reg == high_len - 16'h0001) begin
            state_reg <= fpg_pkg::GEN_LOW;
            cnt_reg <= '0;
            out_reg <= 1'b0;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        fpg_pkg::GEN_LOW: begin
          if (tick_reg && cnt_reg == low_len - 16'h0001) begin
            state_reg <= fpg_pkg::GEN_HIGH;
            cnt_reg <= '0;
            out_reg <= 1'b1;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg + 16'h0001;
          end
        end
        default: begin
          state_reg <= fpg_pkg::GEN_IDLE;
          cnt_reg <= '0;
          out_reg <= ctl.init_level;
        end
      endcase
    end
  end

  // checking aid: cycles since the previous tick
  logic [CW-1:0] gap_reg;
  logic seen_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
    end else if (!ctl.enable || ctl.fast_rate != rate_last_reg) begin
      gap_reg <= '0;
      seen_reg <= 1'b0;
    end else if (tick_reg) begin
      gap_reg <= '0;
      seen_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_high_done;
    state_reg == fpg_pkg::GEN_HIGH && tick_reg && cnt_reg == high_len - 16'h0001;
  endsequence
  sequence s_low_done;
    state_reg == fpg_pkg::GEN_LOW && tick_reg && cnt_reg == low_len - 16'h0001;
  endsequence

  property p_tick_fast;
    tick_reg && seen_reg && rate_last_reg |-> gap_reg == FAST_LAST;
  endproperty
  a_tick_fast: assert property (p_tick_fast) else $error("fast tick spacing wrong");
  property p_tick_slow;
    tick_reg && seen_reg && !rate_last_reg |-> gap_reg == SLOW_LAST;
  endproperty
  a_tick_slow: assert property (p_tick_slow) else $error("slow tick spacing wrong");
  property p_run;
    $rose(ctl.enable) |=> state_reg != fpg_pkg::GEN_IDLE;
  endproperty
  a_run: assert property (p_run) else $error("generator did not start");
  property p_start_level;
    $rose(ctl.enable) |=> ctl.pulse == $past(ctl.init_level);
  endproperty
  a_start_level: assert property (p_start_level) else $error("bad start level");
  property p_high_to_low;
    s_high_done ##1 ctl.enable |-> state_reg == fpg_pkg::GEN_LOW && !ctl.pulse;
  endproperty
  a_high_to_low: assert property (p_high_to_low) else $error("high phase end");
  property p_low_to_high;
    s_low_done ##1 ctl.enable |-> state_reg == fpg_pkg::GEN_HIGH && ctl.pulse;
  endproperty
  a_low_to_high: assert property (p_low_to_high) else $error("low phase end");
  property p_equal_halves;
    ctl.shape_equal && state_reg == fpg_pkg::GEN_LOW && tick_reg &&
      cnt_reg == high_len - 16'h0001 ##1 ctl.enable |-> state_reg == fpg_pkg::GEN_HIGH;
  endproperty
  a_equal_halves: assert property (p_equal_halves) else $error("duty not even");
  property p_stop;
    !ctl.enable |=> state_reg == fpg_pkg::GEN_IDLE && ctl.pulse == $past(ctl.init_level);
  endproperty
  a_stop: assert property (p_stop) else $error("disable did not stop");
endmodule

// ==== verif/serializer_model.sv ====
/*
 * Receive side of the four remote serializers: counts pulse rises seen in back-channel slot 0.
 * Assumes the slot levels are sampled on the hub's core clock.
 */
`timescale 1ns/1ps
module serializer_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // back-channel slots, bit port*4+slot
  input wire logic [15:0] slots,
  // rises of slot 0, one count per port
  output logic [3:0][15:0] slot0_rises
);
  logic [3:0] prev_reg;

  // receive only: a serializer never drives the back channel
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 4'h0;
      slot0_rises <= '0;
    end else begin
      for (int p = 0; p < 4; p++) begin
        prev_reg[p] <= slots[p*4];
        if (slots[p*4] && !prev_reg[p]) begin
          slot0_rises[p] <= slot0_rises[p] + 16'h0001;
        end
      end
    end
  end
endmodule

// ==== verif/testbench.sv ====
/*
 * Self-checking bench of the frame pulse generator: registers, pin relay, internal waveform.
 * Assumes shortened tick counts of 4 (fast) and 8 (slow) core cycles.
 */
`timescale 1ns/1ps
module testbench;
  localparam int FAST = 4;
  localparam int SLOW = 8;
  logic CORE_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_WRITE = 1'b0;
  logic REG_READ = 1'b0;
  logic [7:0] REG_RDATA;
  logic [7:0] GPIO_IN = 8'h00;
  logic [15:0] BC_SLOT_OUT;
  logic FRAME_PULSE_OUT;
  logic [3:0][15:0] rises;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  frame_pulse_generator #(.FAST_CYCLES(FAST), .SLOW_CYCLES(SLOW)) uut (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WRITE(REG_WRITE), .REG_READ(REG_READ), .REG_RDATA(REG_RDATA), .GPIO_IN(GPIO_IN),
    .BC_SLOT_OUT(BC_SLOT_OUT), .FRAME_PULSE_OUT(FRAME_PULSE_OUT));

  serializer_model far_end (.clk(CORE_CLK), .rst_n(RESET_N), .slots(BC_SLOT_OUT),
    .slot0_rises(rises));

  task automatic summarize();
    $display("Checks: %0d, errors: %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WRITE <= 1'b1;
    @(posedge CORE_CLK);
    REG_WRITE <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    REG_ADDR <= a;
    REG_READ <= 1'b1;
    @(posedge CORE_CLK);
    REG_READ <= 1'b0;
    #1;
    check({8'h00, REG_RDATA}, {8'h00, exp}, "register read");
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask

  // waits for the level, then counts edges it lasts; bounded both ways
  task automatic run_len(input logic lvl, output int n);
    for (int k = 0; k < 300 && FRAME_PULSE_OUT !== lvl; k++) wait_cyc(1);
    n = 0;
    while (FRAME_PULSE_OUT === lvl && n < 300) begin
      n++;
      wait_cyc(1);
    end
  endtask

  task automatic set_counts(input logic [7:0] hi, input logic [7:0] lo);
    wr(8'h19, 8'h00);
    wr(8'h1A, hi);
    wr(8'h1B, 8'h00);
    wr(8'h1C, lo);
  endtask

  task automatic test_registers();
    logic [7:0] addrs [7] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h58, 8'h6E};
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(8'h19 + 8'(i), 8'hA5 ^ 8'(i));
      rd_chk(8'h19 + 8'(i), 8'hA5 ^ 8'(i));
    end
    wr(8'h30, 8'hFF);
    rd_chk(8'h30, 8'h00);
    // bit 3 is the live pulse level, low while idle at init level 0
    wr(8'h18, 8'h08);
    rd_chk(8'h18, 8'h00);
  endtask

  task automatic test_relay();
    wr(8'h4C, 8'h0F);
    wr(8'h6E, 8'hAA);
    wr(8'h6F, 8'h00);
    wr(8'h4C, 8'h24);
    wr(8'h6F, 8'h0A);
    rd_chk(8'h6F, 8'h0A);
    for (int p = 0; p < 8; p++) begin
      // enable left clear while relaying a pin
      wr(8'h18, {4'(p + 8), 4'h0});
      @(posedge CORE_CLK);
      GPIO_IN <= 8'h01 << p;
      wait_cyc(8);
      check({15'h0000, FRAME_PULSE_OUT}, 16'h0001, "relay high");
      check(BC_SLOT_OUT, 16'h3733, "routed slots high");
      rd_chk(8'h18, {4'(p + 8), 4'h8});
      @(posedge CORE_CLK);
      GPIO_IN <= ~(8'h01 << p);
      wait_cyc(8);
      check({15'h0000, FRAME_PULSE_OUT}, 16'h0000, "relay low");
      check(BC_SLOT_OUT, 16'h0000, "routed slots low");
    end
    @(posedge CORE_CLK);
    GPIO_IN <= 8'h00;
  endtask

  // disable, program, enable, then measure high and low twice
  task automatic run_wave(input logic [7:0] rate0, input logic [7:0] ctl, input int hi_exp,
      input int lo_exp);
    int n;
    wr(8'h18, 8'h00);
    wr(8'h4C, 8'h0F);
    wr(8'h58, 8'h06);
    wr(8'h4C, 8'h01);
    wr(8'h58, rate0);
    rd_chk(8'h58, rate0);
    wr(8'h18, ctl);
    for (int r = 0; r < 2; r++) begin
      run_len(1'b1, n);
      check(16'(n), 16'(hi_exp), "high length");
      run_len(1'b0, n);
      check(16'(n), 16'(lo_exp), "low length");
    end
  endtask

  task automatic test_internal();
    logic [15:0] rises_start;
    set_counts(8'h02, 8'h03);
    rises_start = rises[0];
    run_wave(8'h06, 8'h01, 2 * FAST, 3 * FAST);
    check(16'(rises[0] > rises_start), 16'h0001, "far end saw pulses");
    for (int p = 1; p < 4; p++) begin
      check(rises[p], rises[0], "ports in step");
    end
    // port 0 slow while the others stay fast: proves the tick comes from port 0
    run_wave(8'h00, 8'h01, 2 * SLOW, 3 * SLOW);
    // source 1 must follow fast port 1, not slow port 0
    run_wave(8'h00, 8'h11, 2 * FAST, 3 * FAST);
    run_wave(8'h06, 8'h03, 2 * FAST, 2 * FAST);
  endtask

  task automatic test_init_level();
    int k;
    wr(8'h18, 8'h04);
    wait_cyc(4);
    check({15'h0000, FRAME_PULSE_OUT}, 16'h0001, "idle at init level");
    rd_chk(8'h18, 8'h0C);
    wr(8'h18, 8'h05);
    wait_cyc(2);
    check({15'h0000, FRAME_PULSE_OUT}, 16'h0001, "starts at init level");
    for (k = 0; k < 200 && FRAME_PULSE_OUT !== 1'b0; k++) wait_cyc(1);
    check(16'(k < 200), 16'h0001, "generator toggles");
    wr(8'h18, 8'h04);
    wait_cyc(3);
    check({15'h0000, FRAME_PULSE_OUT}, 16'h0001, "disable restores level");
    wait_cyc(40);
    check({15'h0000, FRAME_PULSE_OUT}, 16'h0001, "stays stopped");
  endtask

  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      $display("Error at %0t: run did not finish in time", $time);
      summarize();
    end
  end

  initial begin
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    test_registers();
    test_relay();
    test_internal();
    test_init_level();
    summarize();
  end
endmodule
